// ==== mic_multilevel_irq_ctrl.sv ====
`timescale 1ns/10ps
// Overview of operation
// (RQ1) Each source carries a low, medium or high level and is handled by it.
// (RQ2) A pending medium request preempts a running low-level handler.
// (RQ3) A pending high request preempts running medium and low handlers.
// (RQ4) Among equal levels the smallest vector word address is granted.
// (RQ5) Optional round-robin among low-level requests so none starves.
// (RQ6) A non-maskable class exists that level masking cannot block.
// (RQ7) Oscillator failure is non-maskable through vector word address 0x002.
// (RQ8) Peripherals request only while enabled, configured and their condition holds.
// (RQ9) On acknowledge the core loads its program counter with the vector.
// (RQ10) Vector equals peripheral base vector plus the interrupt's offset.
// (RQ11) All vectors are program word addresses, not byte addresses.
// (RQ12) Single-interrupt peripherals use their table entry with no offset.
// (RQ13) The reset entry sits at word address 0x000.
// (RQ14) Port C, R and E bases are 0x004, 0x008 and 0x06C.
// (RQ15) Port B, D, A, G, M bases are 0x04E, 0x060, 0x096, 0x064, 0x068.
// (RQ16) DMA, real-time counter, two-wire bases are 0x00C, 0x014, 0x018.
// (RQ17) Timer C0, timer C1, timer E0 bases are 0x01C, 0x028, 0x074.
// (RQ18) Serial peripheral and block cipher vectors are 0x030 and 0x048.
// (RQ19) UART C0 and UART E0 bases are 0x032 and 0x08A.
// (RQ20) USB, segment display, memory controller bases are 0x03E, 0x046, 0x04A.
// (RQ21) Comparator B, converter B, comparator A, converter A: 0x052, 0x058, 0x09A, 0x0A0.
// (RQ22) After reset no handler is active and round-robin is off.
module mic_multilevel_irq_ctrl
  import mic_pkg::*;
#(
  parameter int NUM_SRC = 8
) (
  input  wire  logic                       SYS_CLK,
  input  wire  logic                       RESETN,
  input  wire  logic [NUM_SRC-1:0]         IRQ_REQ,
  input  wire  logic [NUM_SRC*LVL_W-1:0]   IRQ_LEVEL,
  input  wire  logic [NUM_SRC*PER_W-1:0]   IRQ_PERIPH,
  input  wire  logic [NUM_SRC*OFS_W-1:0]   IRQ_OFFSET,
  input  wire  logic [2:0]                 LEVEL_ENABLE,
  input  wire  logic                       RR_ENABLE,
  input  wire  logic                       OSC_FAIL,
  input  wire  logic                       INT_TAKE,
  input  wire  logic                       INT_RETURN,
  output logic                             INT_REQ,
  output logic [VEC_W-1:0]                 INT_VECTOR,
  output logic [LVL_W-1:0]                 INT_LEVEL,
  output logic                             INT_NMI,
  output logic                             ACK_VALID,
  output logic [$clog2(NUM_SRC+1)-1:0]     ACK_SRC,
  output logic [ACT_W-1:0]                 ACTIVE_LEVELS
);

  localparam int SRC_W = $clog2(NUM_SRC+1);
  localparam int KEY_W = RNK_W + 1 + VEC_W;
  localparam logic [SRC_W-1:0] NMI_SRC_ID = SRC_W'(NUM_SRC);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_OFFER  = 3'b010,
    ST_SETTLE = 3'b100
  } mic_state_t;

  // Table lookup of a peripheral's base or complete vector.
  function automatic logic [VEC_W-1:0] base_of(input logic [PER_W-1:0] per);
    logic [VEC_W-1:0] b;
    b = RESET_VECTOR;
    case (per)
      PER_OSC_FAIL:     b = OSC_FAIL_VECTOR;           // RQ7

      PER_PORT_C:       b = PORT_C_IRQ_BASE;           // RQ14
      PER_PORT_R:       b = PORT_R_IRQ_BASE;           // RQ14
      PER_PORT_E:       b = PORT_E_IRQ_BASE;           // RQ14

      PER_PORT_B:       b = PORT_B_IRQ_BASE;           // RQ15
      PER_PORT_D:       b = PORT_D_IRQ_BASE;           // RQ15
      PER_PORT_A:       b = PORT_A_IRQ_BASE;           // RQ15
      PER_PORT_G:       b = PORT_G_IRQ_BASE;           // RQ15
      PER_PORT_M:       b = PORT_M_IRQ_BASE;           // RQ15

      PER_DMA:          b = DMA_IRQ_BASE;              // RQ16
      PER_RT_COUNTER:   b = RT_COUNTER_IRQ_BASE;       // RQ16
      PER_TWO_WIRE_C:   b = TWO_WIRE_C_IRQ_BASE;       // RQ16

      PER_TIMER_C0:     b = TIMER_C0_IRQ_BASE;         // RQ17
      PER_TIMER_C1:     b = TIMER_C1_IRQ_BASE;         // RQ17
      PER_TIMER_E0:     b = TIMER_E0_IRQ_BASE;         // RQ17

      PER_SERIAL_C:     b = SERIAL_PERIPH_C_VECTOR;    // RQ18
      PER_BLOCK_CIPHER: b = BLOCK_CIPHER_VECTOR;       // RQ18

      PER_UART_C0:      b = UART_C0_IRQ_BASE;          // RQ19
      PER_UART_E0:      b = UART_E0_IRQ_BASE;          // RQ19

      PER_USB_DEV:      b = USB_DEV_IRQ_BASE;          // RQ20
      PER_SEG_DISPLAY:  b = SEG_DISPLAY_IRQ_BASE;      // RQ20
      PER_NVM_CTRL:     b = NVM_CTRL_IRQ_BASE;         // RQ20

      PER_COMPARATOR_B: b = COMPARATOR_B_IRQ_BASE;     // RQ21
      PER_CONVERTER_B:  b = CONVERTER_B_IRQ_BASE;      // RQ21
      PER_COMPARATOR_A: b = COMPARATOR_A_IRQ_BASE;     // RQ21
      PER_CONVERTER_A:  b = CONVERTER_A_IRQ_BASE;      // RQ21

      default:          b = RESET_VECTOR;
    endcase
    return b;
  endfunction : base_of

  // Peripherals with one interrupt only; their entry is the whole vector.
  function automatic logic single_of(input logic [PER_W-1:0] per);
    return (per == PER_OSC_FAIL) ||
           (per == PER_SERIAL_C) ||
           (per == PER_BLOCK_CIPHER);
  endfunction : single_of

  // Word address of one interrupt; no byte scaling is applied anywhere.
  function automatic logic [VEC_W-1:0] vector_of(input logic [PER_W-1:0] per,
                                                 input logic [OFS_W-1:0] ofs);
    logic [VEC_W-1:0] v;
    v = base_of(per);
    if (!single_of(per)) begin                                     // RQ12
      v = v + {{(VEC_W-OFS_W){1'b0}}, ofs};                         // RQ10 RQ11
    end
    return v;
  endfunction : vector_of

  // Level off owns no enable bit and never qualifies; this also keeps the enable index in range.
  function automatic logic level_enabled(input logic [LVL_W-1:0] lvl,
                                         input logic [2:0]       en);
    logic on;
    on = 1'b0;
    case (lvl)
      LVL_OFF:  on = 1'b0;
      LVL_LOW:  on = en[ACT_LOW];
      LVL_MED:  on = en[ACT_MED];
      LVL_HIGH: on = en[ACT_HIGH];
    endcase
    return on;
  endfunction : level_enabled

  // One-hot place in the active vector for a handler of this class.
  function automatic logic [ACT_W-1:0] act_bit_of(input logic             nmi,
                                                  input logic [LVL_W-1:0] lvl);
    logic [ACT_W-1:0] b;
    b = '0;
    if (nmi) begin
      b[ACT_NMI] = 1'b1;
    end else if (lvl != LVL_OFF) begin
      b[lvl - LVL_LOW] = 1'b1;
    end
    return b;
  endfunction : act_bit_of

  mic_state_t             state_r;
  mic_state_t             state_nxt;
  logic [ACT_W-1:0]       active_r;
  logic [ACT_W-1:0]       active_nxt;
  logic [VEC_W-1:0]       last_low_r;
  logic                   rr_en_r;

  // Two-stage synchroniser; only the second stage feeds any logic.
  logic                   osc_s1_r;
  logic                   osc_s2_r;

  // Offer and acknowledge registers drive the outputs directly.
  logic                   int_req_r;
  logic [VEC_W-1:0]       int_vector_r;
  logic [LVL_W-1:0]       int_level_r;
  logic                   int_nmi_r;
  logic [SRC_W-1:0]       offer_src_r;
  logic                   ack_valid_r;
  logic [SRC_W-1:0]       ack_src_r;

  logic [NUM_SRC-1:0]     src_elig;
  logic [KEY_W-1:0]       src_key  [NUM_SRC];
  logic [VEC_W-1:0]       src_vec  [NUM_SRC];
  logic [LVL_W-1:0]       src_lvl  [NUM_SRC];

  logic [RNK_W-1:0]       act_top;
  logic [KEY_W-1:0]       best_key;
  logic [SRC_W-1:0]       best_idx;
  logic                   best_hit;
  logic [VEC_W-1:0]       best_vec;
  logic [LVL_W-1:0]       best_lvl;

  logic                   nmi_elig;
  logic                   any_win;
  logic [VEC_W-1:0]       win_vec;
  logic [LVL_W-1:0]       win_lvl;
  logic [SRC_W-1:0]       win_src;

  logic                   take_ok;
  logic                   reload;
  logic [ACT_W-1:0]       ret_clear;
  logic [ACT_W-1:0]       take_set;

  // The highest running handler sets the bar a new request must clear.
  assign act_top = active_r[ACT_NMI]  ? RANK_NMI :
                   active_r[ACT_HIGH] ? {1'b0, LVL_HIGH} :
                   active_r[ACT_MED]  ? {1'b0, LVL_MED} :
                   active_r[ACT_LOW]  ? {1'b0, LVL_LOW} : RANK_NONE;

  // Each source's fields are packed side by side, source 0 in the lowest bits.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      logic lvl_on;
      logic rr_pref;
      assign src_lvl[gi] = IRQ_LEVEL[gi*LVL_W +: LVL_W];
      assign src_vec[gi] = vector_of(IRQ_PERIPH[gi*PER_W +: PER_W],
                                     IRQ_OFFSET[gi*OFS_W +: OFS_W]);
      // Sources trust the peripheral to request only when enabled and triggered.
      assign lvl_on = level_enabled(src_lvl[gi], LEVEL_ENABLE);               // RQ1 RQ8
      assign src_elig[gi] = IRQ_REQ[gi] && lvl_on && ({1'b0, src_lvl[gi]} > act_top); // RQ2 RQ3
      // Low sources beyond the last serviced one outrank those at or below it.
      assign rr_pref = rr_en_r && (src_lvl[gi] == LVL_LOW) && (src_vec[gi] > last_low_r); // RQ5
      assign src_key[gi] = {{1'b0, src_lvl[gi]}, rr_pref, ~src_vec[gi]};                // RQ1 RQ4
    end
  endgenerate

  // Largest key wins: level first, then round-robin preference, then lowest vector.
  always_comb begin
    best_key = '0;
    best_idx = '0;
    best_hit = 1'b0;
    best_vec = RESET_VECTOR;
    best_lvl = LVL_OFF;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (src_elig[i] && (!best_hit || (src_key[i] > best_key))) begin // RQ4
        best_key = src_key[i];
        best_idx = SRC_W'(i);
        best_hit = 1'b1;
        best_vec = src_vec[i];
        best_lvl = src_lvl[i];
      end
    end
  end

  // Level enables do not gate the oscillator failure class.
  assign nmi_elig = osc_s2_r && !active_r[ACT_NMI];                 // RQ6 RQ7
  assign any_win  = nmi_elig || best_hit;
  assign win_vec  = nmi_elig ? OSC_FAIL_VECTOR : best_vec;          // RQ7
  assign win_lvl  = nmi_elig ? LVL_HIGH : best_lvl;
  assign win_src  = nmi_elig ? NMI_SRC_ID : best_idx;

  assign take_ok = (state_r == ST_OFFER) && INT_TAKE;               // RQ9
  assign reload  = ((state_r == ST_IDLE) || (state_r == ST_OFFER)) && !take_ok;

  // Returning ends the highest running handler; a take in the same cycle still lands.
  assign ret_clear = !INT_RETURN         ? '0 :
                     active_r[ACT_NMI]   ? ACT_W'(1 << ACT_NMI) :
                     active_r[ACT_HIGH]  ? ACT_W'(1 << ACT_HIGH) :
                     active_r[ACT_MED]   ? ACT_W'(1 << ACT_MED) :
                     active_r[ACT_LOW]   ? ACT_W'(1 << ACT_LOW) : '0;
  assign take_set  = take_ok ? act_bit_of(int_nmi_r, int_level_r) : '0;
  assign active_nxt = (active_r & ~ret_clear) | take_set;           // RQ2 RQ3

  // Settle gives the granted peripheral one cycle to drop its request.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (any_win) begin
          state_nxt = ST_OFFER;
        end
      end
      // A take ends the offer; losing every eligible source withdraws it.
      ST_OFFER: begin
        if (INT_TAKE) begin
          state_nxt = ST_SETTLE;
        end else if (!any_win) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_SETTLE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
    end else begin
      osc_s1_r <= OSC_FAIL;
      osc_s2_r <= osc_s1_r;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r    <= ST_IDLE;
      active_r   <= '0;                                             // RQ22
      rr_en_r    <= 1'b0;                                           // RQ22
      last_low_r <= RESET_VECTOR;
    end else begin
      state_r    <= state_nxt;
      active_r   <= active_nxt;
      rr_en_r    <= RR_ENABLE;
      if (take_ok && !int_nmi_r && (int_level_r == LVL_LOW)) begin
        last_low_r <= int_vector_r;                                 // RQ5
      end
    end
  end

  // The offer follows the current winner so a later, higher request replaces it.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      int_req_r    <= 1'b0;
      int_vector_r <= RESET_VECTOR;                                 // RQ13
      int_level_r  <= LVL_OFF;
      int_nmi_r    <= 1'b0;
      offer_src_r  <= '0;
    end else if (reload) begin
      int_req_r    <= any_win;
      int_vector_r <= win_vec;                                      // RQ9
      int_level_r  <= win_lvl;
      int_nmi_r    <= nmi_elig;
      offer_src_r  <= win_src;
    end else begin
      int_req_r    <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_valid_r <= 1'b0;
      ack_src_r   <= '0;
    end else begin
      ack_valid_r <= take_ok;
      if (take_ok) begin
        ack_src_r <= offer_src_r;
      end
    end
  end

  assign INT_REQ       = int_req_r;
  assign INT_VECTOR    = int_vector_r;
  assign INT_LEVEL     = int_level_r;
  assign INT_NMI       = int_nmi_r;
  assign ACK_VALID     = ack_valid_r;
  assign ACK_SRC       = ack_src_r;
  assign ACTIVE_LEVELS = active_r;

endmodule : mic_multilevel_irq_ctrl

// ==== mic_pkg.sv ====
package mic_pkg;

  localparam int VEC_W = 12;
  localparam int OFS_W = 4;
  localparam int PER_W = 5;
  localparam int LVL_W = 2;
  localparam int RNK_W = 3;
  localparam int ACT_W = 4;

  // Interrupt level codes carried on each source's level field.
  localparam logic [LVL_W-1:0] LVL_OFF  = 2'h0;
  localparam logic [LVL_W-1:0] LVL_LOW  = 2'h1;
  localparam logic [LVL_W-1:0] LVL_MED  = 2'h2;
  localparam logic [LVL_W-1:0] LVL_HIGH = 2'h3;

  // Ranks of no running handler and of the non-maskable class, which sits above every maskable level.
  localparam logic [RNK_W-1:0] RANK_NONE = 3'h0;
  localparam logic [RNK_W-1:0] RANK_NMI  = 3'h4;

  // Bit positions in the active-handler vector.
  localparam int ACT_LOW  = 0;
  localparam int ACT_MED  = 1;
  localparam int ACT_HIGH = 2;
  localparam int ACT_NMI  = 3;

  // Word addresses of the reset and interrupt vector table.
  localparam logic [VEC_W-1:0] RESET_VECTOR              = 12'h000;
  localparam logic [VEC_W-1:0] OSC_FAIL_VECTOR           = 12'h002;
  localparam logic [VEC_W-1:0] PORT_C_IRQ_BASE           = 12'h004;
  localparam logic [VEC_W-1:0] PORT_R_IRQ_BASE           = 12'h008;
  localparam logic [VEC_W-1:0] DMA_IRQ_BASE              = 12'h00c;
  localparam logic [VEC_W-1:0] RT_COUNTER_IRQ_BASE       = 12'h014;
  localparam logic [VEC_W-1:0] TWO_WIRE_C_IRQ_BASE       = 12'h018;
  localparam logic [VEC_W-1:0] TIMER_C0_IRQ_BASE         = 12'h01c;
  localparam logic [VEC_W-1:0] TIMER_C1_IRQ_BASE         = 12'h028;
  localparam logic [VEC_W-1:0] SERIAL_PERIPH_C_VECTOR    = 12'h030;
  localparam logic [VEC_W-1:0] UART_C0_IRQ_BASE          = 12'h032;
  localparam logic [VEC_W-1:0] USB_DEV_IRQ_BASE          = 12'h03e;
  localparam logic [VEC_W-1:0] SEG_DISPLAY_IRQ_BASE      = 12'h046;
  localparam logic [VEC_W-1:0] BLOCK_CIPHER_VECTOR       = 12'h048;
  localparam logic [VEC_W-1:0] NVM_CTRL_IRQ_BASE         = 12'h04a;
  localparam logic [VEC_W-1:0] PORT_B_IRQ_BASE           = 12'h04e;
  localparam logic [VEC_W-1:0] COMPARATOR_B_IRQ_BASE     = 12'h052;
  localparam logic [VEC_W-1:0] CONVERTER_B_IRQ_BASE      = 12'h058;
  localparam logic [VEC_W-1:0] PORT_D_IRQ_BASE           = 12'h060;
  localparam logic [VEC_W-1:0] PORT_G_IRQ_BASE           = 12'h064;
  localparam logic [VEC_W-1:0] PORT_M_IRQ_BASE           = 12'h068;
  localparam logic [VEC_W-1:0] PORT_E_IRQ_BASE           = 12'h06c;
  localparam logic [VEC_W-1:0] TIMER_E0_IRQ_BASE         = 12'h074;
  localparam logic [VEC_W-1:0] UART_E0_IRQ_BASE          = 12'h08a;
  localparam logic [VEC_W-1:0] PORT_A_IRQ_BASE           = 12'h096;
  localparam logic [VEC_W-1:0] COMPARATOR_A_IRQ_BASE     = 12'h09a;
  localparam logic [VEC_W-1:0] CONVERTER_A_IRQ_BASE      = 12'h0a0;

  // Peripheral identifiers presented on each source's peripheral field.
  localparam logic [PER_W-1:0] PER_OSC_FAIL     = 5'h00;
  localparam logic [PER_W-1:0] PER_PORT_C       = 5'h01;
  localparam logic [PER_W-1:0] PER_PORT_R       = 5'h02;
  localparam logic [PER_W-1:0] PER_DMA          = 5'h03;
  localparam logic [PER_W-1:0] PER_RT_COUNTER   = 5'h04;
  localparam logic [PER_W-1:0] PER_TWO_WIRE_C   = 5'h05;
  localparam logic [PER_W-1:0] PER_TIMER_C0     = 5'h06;
  localparam logic [PER_W-1:0] PER_TIMER_C1     = 5'h07;
  localparam logic [PER_W-1:0] PER_SERIAL_C     = 5'h08;
  localparam logic [PER_W-1:0] PER_UART_C0      = 5'h09;
  localparam logic [PER_W-1:0] PER_USB_DEV      = 5'h0a;
  localparam logic [PER_W-1:0] PER_SEG_DISPLAY  = 5'h0b;
  localparam logic [PER_W-1:0] PER_BLOCK_CIPHER = 5'h0c;
  localparam logic [PER_W-1:0] PER_NVM_CTRL     = 5'h0d;
  localparam logic [PER_W-1:0] PER_PORT_B       = 5'h0e;
  localparam logic [PER_W-1:0] PER_COMPARATOR_B = 5'h0f;
  localparam logic [PER_W-1:0] PER_CONVERTER_B  = 5'h10;
  localparam logic [PER_W-1:0] PER_PORT_D       = 5'h11;
  localparam logic [PER_W-1:0] PER_PORT_G       = 5'h12;
  localparam logic [PER_W-1:0] PER_PORT_M       = 5'h13;
  localparam logic [PER_W-1:0] PER_PORT_E       = 5'h14;
  localparam logic [PER_W-1:0] PER_TIMER_E0     = 5'h15;
  localparam logic [PER_W-1:0] PER_UART_E0      = 5'h16;
  localparam logic [PER_W-1:0] PER_PORT_A       = 5'h17;
  localparam logic [PER_W-1:0] PER_COMPARATOR_A = 5'h18;
  localparam logic [PER_W-1:0] PER_CONVERTER_A  = 5'h19;

endpackage : mic_pkg

// ==== mic_irq_checker_assertions.sv ====
`timescale 1ns/10ps
module mic_irq_checker
  import mic_pkg::*;
#(
  parameter int NUM_SRC = 8
) (
  input wire logic                         SYS_CLK,
  input wire logic                         RESETN,
  input wire logic                         OSC_FAIL,
  input wire logic                         INT_TAKE,
  input wire logic                         INT_RETURN,
  input wire logic                         INT_REQ,
  input wire logic [VEC_W-1:0]             INT_VECTOR,
  input wire logic [LVL_W-1:0]             INT_LEVEL,
  input wire logic                         INT_NMI,
  input wire logic                         ACK_VALID,
  input wire logic [$clog2(NUM_SRC+1)-1:0] ACK_SRC,
  input wire logic [ACT_W-1:0]             ACTIVE_LEVELS
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);

  // The settle cycle after a take gives the peripheral time to drop its request.
  a_take_acked: assert property (INT_REQ && INT_TAKE |=> ACK_VALID && !INT_REQ ##1 !INT_REQ)
    else $error("take not acknowledged with a settle cycle");
  a_ack_single: assert property (ACK_VALID |=> !ACK_VALID)
    else $error("acknowledge longer than one cycle");
  a_ack_caused: assert property (ACK_VALID |-> $past(INT_REQ) && $past(INT_TAKE))
    else $error("acknowledge without a take");
  a_nmi_vector: assert property (INT_REQ && INT_NMI |-> INT_VECTOR == 12'h002 && INT_LEVEL == LVL_HIGH)
    else $error("non-maskable offer has wrong vector");
  a_level_valid: assert property (INT_REQ && !INT_NMI |-> INT_LEVEL != LVL_OFF)
    else $error("offer carries level off");
  a_preempt_only: assert property (INT_REQ && !INT_NMI |-> !ACTIVE_LEVELS[ACT_NMI] &&
    (ACTIVE_LEVELS[ACT_HIGH:ACT_LOW] >> (INT_LEVEL - 2'h1)) == 3'h0)
    else $error("offer does not outrank running handler");
  a_level_active: assert property (INT_REQ && INT_TAKE && !INT_NMI |=> ACTIVE_LEVELS[$past(INT_LEVEL) - 2'h1])
    else $error("taken level not marked active");
  a_nmi_active: assert property (INT_REQ && INT_TAKE && INT_NMI |=> ACTIVE_LEVELS[ACT_NMI])
    else $error("taken non-maskable not marked active");
  a_nmi_return: assert property (INT_RETURN && !INT_TAKE && ACTIVE_LEVELS[ACT_NMI] |=> !ACTIVE_LEVELS[ACT_NMI])
    else $error("return did not end non-maskable handler");
  a_nmi_offered: assert property ($rose(OSC_FAIL) && !INT_REQ && !ACTIVE_LEVELS[ACT_NMI] |->
    ##[1:3] INT_REQ && INT_NMI)
    else $error("oscillator failure not offered in time");
endmodule : mic_irq_checker

bind mic_multilevel_irq_ctrl mic_irq_checker #(.NUM_SRC(NUM_SRC)) u_chk (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .OSC_FAIL(OSC_FAIL), .INT_TAKE(INT_TAKE), .INT_RETURN(INT_RETURN),
  .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR), .INT_LEVEL(INT_LEVEL), .INT_NMI(INT_NMI),
  .ACK_VALID(ACK_VALID), .ACK_SRC(ACK_SRC), .ACTIVE_LEVELS(ACTIVE_LEVELS)
);

// ==== mic_core_model.sv ====
`timescale 1ns/10ps
module mic_core_model
  import mic_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             int_req,
  input  wire logic [VEC_W-1:0] int_vector,
  input  wire logic             take_en,
  input  wire logic [3:0]       take_wait,
  input  wire logic             ret_go,
  output logic                  int_take,
  output logic                  int_return,
  output logic [VEC_W-1:0]      pc_r
);
  logic [3:0] wait_r;

  // A slow core lets the offer be refreshed several times before it takes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_take   <= 1'b0;
      int_return <= 1'b0;
      wait_r     <= 4'h0;
      pc_r       <= 12'h000;
    end else begin
      int_take   <= take_en && int_req && !int_take && wait_r >= take_wait;
      wait_r     <= (take_en && int_req && !int_take) ? wait_r + 4'h1 : 4'h0;
      int_return <= ret_go;
      if (int_take && int_req) begin
        pc_r <= int_vector;
      end
    end
  end
endmodule : mic_core_model

// ==== mic_multilevel_irq_ctrl_tb.sv ====
`timescale 1ns/10ps
module mic_multilevel_irq_ctrl_tb
  import mic_pkg::*;
();
  localparam int NS = 8;
  logic                SYS_CLK = 1'b0;
  logic                RESETN;
  logic [NS-1:0]       irq_req;
  logic [NS*LVL_W-1:0] irq_level;
  logic [NS*PER_W-1:0] irq_per;
  logic [NS*OFS_W-1:0] irq_ofs;
  logic [2:0]          lvl_en;
  logic                rr_en, osc_fail, take_en, ret_go;
  logic [3:0]          take_wait, ack_src;
  logic                int_take, int_ret, int_req, int_nmi, ack_valid;
  logic [VEC_W-1:0]    int_vec, pc;
  logic [LVL_W-1:0]    int_lvl;
  logic [ACT_W-1:0]    active;
  logic [15:0]         notes[$];
  logic [31:0]         seed = 32'h4bdae1cd;
  int                  miscompares = 0;
  int                  checked = 0;
  logic [VEC_W-1:0]    base_tab [26] = '{12'h002, 12'h004, 12'h008, 12'h00c, 12'h014, 12'h018, 12'h01c,
    12'h028, 12'h030, 12'h032, 12'h03e, 12'h046, 12'h048, 12'h04a, 12'h04e, 12'h052, 12'h058, 12'h060,
    12'h064, 12'h068, 12'h06c, 12'h074, 12'h08a, 12'h096, 12'h09a, 12'h0a0};

  mic_multilevel_irq_ctrl #(.NUM_SRC(NS)) dut (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .IRQ_REQ(irq_req), .IRQ_LEVEL(irq_level),
    .IRQ_PERIPH(irq_per), .IRQ_OFFSET(irq_ofs), .LEVEL_ENABLE(lvl_en), .RR_ENABLE(rr_en),
    .OSC_FAIL(osc_fail), .INT_TAKE(int_take), .INT_RETURN(int_ret), .INT_REQ(int_req),
    .INT_VECTOR(int_vec), .INT_LEVEL(int_lvl), .INT_NMI(int_nmi), .ACK_VALID(ack_valid),
    .ACK_SRC(ack_src), .ACTIVE_LEVELS(active)
  );
  mic_core_model core (
    .clk(SYS_CLK), .rst_n(RESETN), .int_req(int_req), .int_vector(int_vec), .take_en(take_en),
    .take_wait(take_wait), .ret_go(ret_go), .int_take(int_take), .int_return(int_ret), .pc_r(pc)
  );

  always #20 SYS_CLK = ~SYS_CLK;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Each source changes on its own edge so no vector gets two updates in one step.
  task automatic set_src(input int i, input logic [1:0] lvl, input logic [4:0] per, input logic [3:0] ofs,
                         input logic req);
    @(posedge SYS_CLK);
    irq_level[i*LVL_W +: LVL_W] <= lvl;
    irq_per[i*PER_W +: PER_W]   <= per;
    irq_ofs[i*OFS_W +: OFS_W]   <= ofs;
    irq_req[i]                  <= req;
  endtask : set_src

  task automatic take(input logic [11:0] vec, input logic [3:0] src);
    notes.push_back({vec, src});
    take_en <= 1'b1;
    for (int n = 0; n < 40 && ack_valid !== 1'b1; n++) @(posedge SYS_CLK);
    take_en <= 1'b0;
  endtask : take

  task automatic ret();
    ret_go <= 1'b1;
    @(posedge SYS_CLK);
    ret_go <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
  endtask : ret

  task automatic no_offer();
    repeat (4) @(posedge SYS_CLK);
    chk("offer refused", {15'h0, int_req}, 16'h0);
  endtask : no_offer

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  always @(posedge SYS_CLK) begin
    if (ack_valid === 1'b1) begin
      if (notes.size() == 0) chk("unexpected acknowledge", 16'h0, 16'h1);
      else chk("taken vector and source", {pc, ack_src}, notes.pop_front());
    end
  end

  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial begin
    int         s;
    logic [3:0] ofs;
    {irq_req, irq_level, irq_per, irq_ofs} = '0;
    lvl_en = 3'h7;
    {rr_en, osc_fail, take_en, ret_go, RESETN} = 5'h0;
    take_wait = 4'h0;
    repeat (10) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    @(posedge SYS_CLK);
    chk("state after reset", {int_req, int_vec, active[2:0]}, 16'h0);
    for (int p = 0; p < 26; p++) begin
      seed = lfsr(seed);
      s = int'(seed[2:0]);
      ofs = seed[6:3];
      take_wait <= {1'b0, seed[10:8]};
      set_src(s, LVL_LOW, p[4:0], ofs, 1'b1);
      take(base_tab[p] + ((p == 0 || p == 8 || p == 12) ? 12'h0 : {8'h0, ofs}),
           s[3:0]);
      set_src(s, LVL_OFF, p[4:0], ofs, 1'b0);
      ret();
    end
    set_src(0, LVL_LOW, PER_PORT_C, 4'h1, 1'b1);
    take(12'h005, 4'h0);
    set_src(0, LVL_OFF, PER_PORT_C, 4'h1, 1'b0);
    set_src(1, LVL_LOW, PER_PORT_A, 4'h0, 1'b1);
    set_src(5, LVL_LOW, PER_DMA, 4'h2, 1'b1);
    no_offer();
    set_src(3, LVL_MED, PER_TIMER_C0, 4'h0, 1'b1);
    take(12'h01c, 4'h3);
    set_src(3, LVL_OFF, PER_TIMER_C0, 4'h0, 1'b0);
    set_src(4, LVL_HIGH, PER_CONVERTER_A, 4'h3, 1'b1);
    take(12'h0a3, 4'h4);
    set_src(4, LVL_OFF, PER_CONVERTER_A, 4'h3, 1'b0);
    chk("active levels", {12'h0, active}, 16'h0007);
    ret();
    ret();
    no_offer();
    ret();
    take(12'h00e, 4'h5);
    set_src(5, LVL_OFF, PER_DMA, 4'h2, 1'b0);
    ret();
    take(12'h096, 4'h1);
    set_src(1, LVL_OFF, PER_PORT_A, 4'h0, 1'b0);
    ret();
    lvl_en <= 3'h6;
    set_src(6, LVL_LOW, PER_PORT_G, 4'h0, 1'b1);
    no_offer();
    lvl_en <= 3'h7;
    take(12'h064, 4'h6);
    set_src(6, LVL_OFF, PER_PORT_G, 4'h0, 1'b0);
    lvl_en <= 3'h0;
    osc_fail <= 1'b1;
    take(12'h002, 4'h8);
    chk("active levels", {12'h0, active}, 16'h0009);
    osc_fail <= 1'b0;
    lvl_en <= 3'h7;
    ret();
    ret();
    rr_en <= 1'b1;
    set_src(0, LVL_LOW, PER_PORT_C, 4'h0, 1'b1);
    set_src(7, LVL_LOW, PER_PORT_B, 4'h0, 1'b1);
    for (int k = 0; k < 5; k++) begin
      take((k == 1) ? 12'h04e : 12'h004, (k == 1) ? 4'h7 : 4'h0);
      if (k == 2) rr_en <= 1'b0;
      ret();
    end
    chk("notes left", 16'(notes.size()), 16'h0);
    complete_run();
  end
endmodule : mic_multilevel_irq_ctrl_tb
